// [rtl/byte_op_pkg.sv]
// Constants and types for the byte-oriented file-register decoder.
// Assumes a single core clock and an active-low asynchronous reset.
package byte_op_pkg;
  localparam int INSTR_W = 14;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int BUS_AW = 8;
  // Instruction word fields
  localparam int OP_LSB = 8;
  localparam int D_BIT = 7;
  localparam int BIT_LSB = 7;
  localparam logic [1:0] OP_CLASS_BYTE = 2'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;
  // File address of the second I/O port
  localparam logic [ADDR_W-1:0] PORT2_ADDR = 7'h06;
  // Register port map above the file registers
  localparam logic [BUS_AW-1:0] BUS_ACC = 8'h80;
  localparam logic [BUS_AW-1:0] BUS_STATUS = 8'h81;
  localparam logic [BUS_AW-1:0] BUS_CTRL = 8'h82;
  // Status and control bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int CTRL_FLAG = 0;
  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] PORT_RST = 8'h00;
  typedef enum logic [2:0] {alu_pass, alu_add, alu_and, alu_clr, alu_dec, alu_inc} alu_op_type;
  typedef enum logic [1:0] {ph_decode, ph_read, ph_modify, ph_write} phase_type;
endpackage : byte_op_pkg

// [rtl/alu_if.sv]
// Operand and result bundle between the decoder core and its byte ALU.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface alu_if;
  import byte_op_pkg::*;
  alu_op_type op;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] result;
  logic c;
  logic dc;
  logic z;
  modport core (output op, a, w, input result, c, dc, z);
  modport alu (input op, a, w, output result, c, dc, z);
endinterface : alu_if

// [rtl/byte_alu.sv]
// Combinational byte ALU for the file-register operations.
// Assumes operands are held stable by the core across the cycle.
`timescale 1ns/1ps
module byte_alu
(
  alu_if.alu bus
);
  import byte_op_pkg::*;
  logic [DATA_W:0] sum9;
  logic [4:0] nib;

  always_comb
  begin
    sum9 = {1'b0, bus.a} + {1'b0, bus.w};
    nib = {1'b0, bus.a[3:0]} + {1'b0, bus.w[3:0]};
    bus.c = 1'b0;
    bus.dc = 1'b0;
    bus.result = bus.a;
    unique case (bus.op)
      alu_add:
      begin
        bus.result = sum9[DATA_W-1:0];
        bus.c = sum9[DATA_W];
        bus.dc = nib[4];
      end
      alu_and: bus.result = bus.a & bus.w;
      alu_clr: bus.result = 8'h00;
      alu_dec: bus.result = bus.a - 8'h01;
      alu_inc: bus.result = bus.a + 8'h01;
      alu_pass: bus.result = bus.a;
    endcase
    bus.z = (bus.result == 8'h00);
  end
endmodule : byte_alu

// [rtl/byte_op_file_register_decoder.sv]
// Decoder and executor for byte-oriented file-register instructions.
// Assumes a fetch unit presents a word on instr_in while fetch_out is high.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module byte_op_file_register_decoder
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Instruction stream
  input wire logic [byte_op_pkg::INSTR_W-1:0] instr_in,
  output logic fetch_out,
  output logic skip_pending_out,
  output logic [byte_op_pkg::DATA_W-1:0] bit_mask_out,
  // Register port
  input wire logic [byte_op_pkg::BUS_AW-1:0] addr_in,
  input wire logic [byte_op_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [byte_op_pkg::DATA_W-1:0] rd_data_out,
  // Core state
  output logic [byte_op_pkg::DATA_W-1:0] acc_out,
  output logic [byte_op_pkg::DATA_W-1:0] status_out,
  // Second I/O port
  input wire logic [byte_op_pkg::DATA_W-1:0] second_io_port_in,
  output logic [byte_op_pkg::DATA_W-1:0] second_io_port_out,
  output logic port_change_flag_out
);
  import byte_op_pkg::*;

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  phase_type phase_r, phase_nxt;
  logic [INSTR_W-1:0] instr_r, instr_nxt;
  logic [DATA_W-1:0] opnd_r, opnd_nxt;
  logic [DATA_W-1:0] result_r, result_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [DATA_W-1:0] status_r, status_nxt;
  logic [DATA_W-1:0] port_out_r, port_out_nxt;
  logic [DATA_W-1:0] snap_r, snap_nxt;
  logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
  logic [DATA_W-1:0] bit_mask_r, bit_mask_nxt;
  logic [DATA_W-1:0] pins_s1_r, pins_s2_r;
  logic flag_r, flag_nxt;
  logic skip_r, skip_nxt;
  logic fetch_r;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;
  logic [3:0] op4;
  logic byte_cls, is_clear_register_op, is_clear_accumulator_op, file_op, skip_op, dest_file, writes_acc;
  logic [ADDR_W-1:0] faddr;
  alu_if alu_bus ();

  byte_alu u_alu
  (
    .bus(alu_bus.alu)
  );

  // Field decode of the held word
  always_comb
  begin
    op4 = instr_r[OP_LSB+3:OP_LSB];
    byte_cls = (instr_r[INSTR_W-1:INSTR_W-2] == OP_CLASS_BYTE);
    faddr = instr_r[ADDR_W-1:0];
    is_clear_register_op = byte_cls && (op4 == OP_CLR) && instr_r[D_BIT];
    is_clear_accumulator_op = byte_cls && (op4 == OP_CLR) && !instr_r[D_BIT];
    skip_op = byte_cls && ((op4 == OP_DECSZ) || (op4 == OP_INCSZ));
    file_op = is_clear_register_op || skip_op || (byte_cls && ((op4 == OP_ADD) || (op4 == OP_AND)));
    dest_file = is_clear_register_op || (file_op && instr_r[D_BIT]);
    writes_acc = is_clear_accumulator_op || (file_op && !dest_file);
    alu_bus.op = alu_pass;
    if (is_clear_register_op || is_clear_accumulator_op)
      alu_bus.op = alu_clr;
    else if (byte_cls && op4 == OP_ADD)
      alu_bus.op = alu_add;
    else if (byte_cls && op4 == OP_AND)
      alu_bus.op = alu_and;
    else if (byte_cls && op4 == OP_DECSZ)
      alu_bus.op = alu_dec;
    else if (byte_cls && op4 == OP_INCSZ)
      alu_bus.op = alu_inc;
    alu_bus.a = opnd_r;
    alu_bus.w = acc_r;
  end

  // Core sequencing, register port and change detect
  always_comb
  begin
    phase_nxt = phase_r;
    instr_nxt = instr_r;
    opnd_nxt = opnd_r;
    result_nxt = result_r;
    acc_nxt = acc_r;
    status_nxt = status_r;
    port_out_nxt = port_out_r;
    snap_nxt = snap_r;
    skip_nxt = skip_r;
    bit_mask_nxt = bit_mask_r;
    rd_data_nxt = 8'h00;
    mem_we = 1'b0;
    mem_wa = addr_in[ADDR_W-1:0];
    mem_wd = wr_data_in;
    // Register port writes, overridden by a core write below
    if (wr_in && !addr_in[BUS_AW-1])
    begin
      if (addr_in[ADDR_W-1:0] == PORT2_ADDR)
        port_out_nxt = wr_data_in;
      else
        mem_we = 1'b1;
    end
    if (rd_in)
    begin
      if (!addr_in[BUS_AW-1])
        rd_data_nxt = (addr_in[ADDR_W-1:0] == PORT2_ADDR) ? pins_s2_r : mem[addr_in[ADDR_W-1:0]];
      else if (addr_in == BUS_ACC)
        rd_data_nxt = acc_r;
      else if (addr_in == BUS_STATUS)
        rd_data_nxt = status_r;
      else if (addr_in == BUS_CTRL)
        rd_data_nxt = {7'h00, flag_r};
    end
    unique case (phase_r)
      ph_decode:
      begin
        instr_nxt = skip_r ? NOP_WORD : instr_in;
        bit_mask_nxt = 8'h01 << instr_in[BIT_LSB+2:BIT_LSB];
        skip_nxt = 1'b0;
        phase_nxt = ph_read;
      end
      ph_read:
      begin
        opnd_nxt = (faddr == PORT2_ADDR) ? pins_s2_r : mem[faddr];
        if (file_op && faddr == PORT2_ADDR)
          snap_nxt = pins_s2_r;
        phase_nxt = ph_modify;
      end
      ph_modify:
      begin
        result_nxt = alu_bus.result;
        phase_nxt = ph_write;
      end
      ph_write:
      begin
        if (file_op && dest_file)
        begin
          if (faddr == PORT2_ADDR)
            port_out_nxt = result_r;
          else
          begin
            mem_we = 1'b1;
            mem_wa = faddr;
            mem_wd = result_r;
          end
        end
        if (writes_acc)
          acc_nxt = result_r;
        if (alu_bus.op == alu_add)
        begin
          status_nxt[ST_C] = alu_bus.c;
          status_nxt[ST_DC] = alu_bus.dc;
        end
        if (alu_bus.op == alu_add || alu_bus.op == alu_and || alu_bus.op == alu_clr)
          status_nxt[ST_Z] = (result_r == 8'h00);
        skip_nxt = skip_op && (result_r == 8'h00);
        phase_nxt = ph_decode;
      end
    endcase
    // Mismatch sets the flag; a set wins over a clear
    flag_nxt = (flag_r & ~(wr_in && addr_in == BUS_CTRL && !wr_data_in[CTRL_FLAG]))
      | (pins_s2_r != snap_r);
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      phase_r <= ph_decode;
      instr_r <= NOP_WORD;
      opnd_r <= 8'h00;
      result_r <= 8'h00;
      acc_r <= ACC_RST;
      status_r <= STATUS_RST;
      port_out_r <= PORT_RST;
      snap_r <= 8'h00;
      rd_data_r <= 8'h00;
      bit_mask_r <= 8'h00;
      pins_s1_r <= 8'h00;
      pins_s2_r <= 8'h00;
      flag_r <= 1'b0;
      skip_r <= 1'b0;
      fetch_r <= 1'b1;
    end
    else
    begin
      phase_r <= phase_nxt;
      instr_r <= instr_nxt;
      opnd_r <= opnd_nxt;
      result_r <= result_nxt;
      acc_r <= acc_nxt;
      status_r <= status_nxt;
      port_out_r <= port_out_nxt;
      snap_r <= snap_nxt;
      rd_data_r <= rd_data_nxt;
      bit_mask_r <= bit_mask_nxt;
      pins_s1_r <= second_io_port_in;
      pins_s2_r <= pins_s1_r;
      flag_r <= flag_nxt;
      skip_r <= skip_nxt;
      fetch_r <= (phase_nxt == ph_decode);
    end
  end

  // File register storage
  always_ff @(posedge sys_clk_in)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign fetch_out = fetch_r;
  assign skip_pending_out = skip_r;
  assign bit_mask_out = bit_mask_r;
  assign rd_data_out = rd_data_r;
  assign acc_out = acc_r;
  assign status_out = status_r;
  assign second_io_port_out = port_out_r;
  assign port_change_flag_out = flag_r;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_fetch_gap;
    !fetch_r [*3] ##1 fetch_r;
  endsequence
  sequence s_skip_write;
    phase_r == ph_write && skip_op && result_r == 8'h00;
  endsequence

  a_fetch_every_four: assert property (fetch_r |=> s_fetch_gap)
    else $error("fetch strobe not every four clocks");
  a_read_then_write: assert property (phase_r == ph_read |-> ##2 phase_r == ph_write)
    else $error("write phase not two clocks after read");
  a_port_snapshot: assert property (phase_r == ph_read && file_op && faddr == PORT2_ADDR
    |=> snap_r == $past(pins_s2_r))
    else $error("port read did not refresh snapshot");
  a_acc_dest: assert property (phase_r == ph_write && writes_acc |=> acc_r == $past(result_r))
    else $error("accumulator not written");
  a_file_dest: assert property (phase_r == ph_write && file_op && dest_file && faddr != PORT2_ADDR
    |=> mem[$past(faddr)] == $past(result_r))
    else $error("file register not written");
  a_skip_nop: assert property (s_skip_write |=> skip_r ##1 instr_r == NOP_WORD)
    else $error("skipped instruction not replaced by no-op");
  a_dec_value: assert property (phase_r == ph_modify && alu_bus.op == alu_dec
    |=> result_r == $past(opnd_r) - 8'h01)
    else $error("decrement result wrong");
  a_inc_value: assert property (phase_r == ph_modify && alu_bus.op == alu_inc
    |=> result_r == $past(opnd_r) + 8'h01)
    else $error("increment result wrong");
  a_clear_zero: assert property (phase_r == ph_write && alu_bus.op == alu_clr
    |=> status_r[ST_Z])
    else $error("clear did not set zero flag");
endmodule : byte_op_file_register_decoder

// [test/tb_top.sv]
// Self-checking bench for the byte-oriented file-register decoder.
// Assumes byte_op_pkg is compiled first; the bench drives every port.
`timescale 1ns/1ps
module tb_top;
  import byte_op_pkg::*;
  logic sys_clk_in;
  logic resetn_in;
  logic [INSTR_W-1:0] instr_in;
  logic fetch_out;
  logic skip_pending_out;
  logic [DATA_W-1:0] bit_mask_out;
  logic [BUS_AW-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in;
  logic wr_in;
  logic rd_in;
  logic [DATA_W-1:0] rd_data_out;
  logic [DATA_W-1:0] acc_out;
  logic [DATA_W-1:0] status_out;
  logic [DATA_W-1:0] second_io_port_in;
  logic [DATA_W-1:0] second_io_port_out;
  logic port_change_flag_out;
  int n_fail;
  int checked;
  int seed;
  int m_acc;
  int m_st;
  int mem [128];
  bit m_skip;

  byte_op_file_register_decoder dut_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .instr_in(instr_in), .fetch_out(fetch_out), .skip_pending_out(skip_pending_out),
    .bit_mask_out(bit_mask_out), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .acc_out(acc_out),
    .status_out(status_out), .second_io_port_in(second_io_port_in),
    .second_io_port_out(second_io_port_out), .port_change_flag_out(port_change_flag_out));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // Reference behaviour of one sampled word
  task automatic model(input logic [INSTR_W-1:0] w);
    int a;
    int r;
    a = mem[w[6:0]];
    r = -1;
    if (m_skip || w[13:12] != OP_CLASS_BYTE)
    begin
      m_skip = 0;
      return;
    end
    case (w[11:8])
      OP_ADD:
      begin
        r = (m_acc + a) & 255;
        m_st = ((m_acc + a > 255) ? 1 : 0) | (((m_acc & 15) + (a & 15) > 15) ? 2 : 0);
        m_st = m_st | ((r == 0) ? 4 : 0);
      end
      OP_AND:
      begin
        r = m_acc & a;
        m_st = (m_st & 3) | ((r == 0) ? 4 : 0);
      end
      OP_CLR:
      begin
        r = 0;
        m_st = m_st | 4;
      end
      OP_DECSZ: r = (a + 255) & 255;
      OP_INCSZ: r = (a + 1) & 255;
      default: r = -1;
    endcase
    if ((w[11:8] == OP_DECSZ || w[11:8] == OP_INCSZ) && r == 0)
      m_skip = 1;
    if (r >= 0)
      if (w[D_BIT])
        mem[w[6:0]] = r;
      else
        m_acc = r;
  endtask : model

  task automatic bus_wr(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [BUS_AW-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 v = rd_data_out;
  endtask : bus_rd

  // Two words sampled back to back
  task automatic exec(input logic [INSTR_W-1:0] w1, input logic [INSTR_W-1:0] w2);
    int k;
    k = 0;
    @(negedge sys_clk_in);
    while (fetch_out !== 1'b1 && k < 8)
    begin
      @(negedge sys_clk_in);
      k++;
    end
    chk("fetch_wait", 8'h01, {7'h00, fetch_out});
    repeat (4) @(posedge sys_clk_in);
    instr_in <= w1;
    @(posedge sys_clk_in);
    instr_in <= w2;
    model(w1);
    #1 chk("bit_mask", 8'h01 << w1[9:7], bit_mask_out);
    chk("fetch_low", 8'h00, {7'h00, fetch_out});
    repeat (3) @(posedge sys_clk_in);
    #1 chk("fetch_high", 8'h01, {7'h00, fetch_out});
    chk("acc_w1", m_acc[7:0], acc_out);
    chk("status_w1", m_st[7:0], status_out);
    chk("skip", {7'h00, m_skip}, {7'h00, skip_pending_out});
    @(posedge sys_clk_in);
    instr_in <= NOP_WORD;
    model(w2);
    m_skip = 0;
    repeat (3) @(posedge sys_clk_in);
    #1 chk("acc_w2", m_acc[7:0], acc_out);
    chk("status_w2", m_st[7:0], status_out);
  endtask : exec

  initial
  begin
    #80000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    logic [DATA_W-1:0] v;
    logic [INSTR_W-1:0] w1;
    logic [INSTR_W-1:0] w2;
    logic [6:0] f1;
    logic [6:0] f2;
    logic dsel;
    logic [3:0] op_tab [5];
    op_tab = '{OP_CLR, OP_AND, OP_ADD, OP_DECSZ, OP_INCSZ};
    seed = 58;
    n_fail = 0;
    checked = 0;
    m_acc = 0;
    m_st = 0;
    m_skip = 0;
    resetn_in = 1'b0;
    instr_in = NOP_WORD;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    second_io_port_in = 8'h00;
    repeat (5) @(posedge sys_clk_in);
    #1 chk("fetch_rst", 8'h01, {7'h00, fetch_out});
    chk("acc_rst", ACC_RST, acc_out);
    chk("status_rst", STATUS_RST, status_out);
    repeat (5) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      f1 = 7'h10 + 7'(3'($random(seed)));
      f2 = 7'h78 + 7'(3'($random(seed)));
      v = (i % 4 == 1) ? 8'h01 : (i % 4 == 3) ? 8'hFF : 8'($random(seed));
      bus_wr({1'b0, f1}, v);
      mem[f1] = v;
      v = 8'($random(seed));
      bus_wr({1'b0, f2}, v);
      mem[f2] = v;
      dsel = 1'($random(seed));
      w1 = {OP_CLASS_BYTE, op_tab[i % 5], dsel, f1};
      if (op_tab[i % 5] == OP_CLR && !dsel)
        w1[6:0] = 7'($random(seed));
      w2 = (i % 3 == 0) ? {2'h3, 12'($random(seed))} : {OP_CLASS_BYTE, OP_ADD, 1'b1, f2};
      exec(w1, w2);
      bus_rd({1'b0, f1}, v);
      chk("file_f1", mem[f1][7:0], v);
      bus_rd({1'b0, f2}, v);
      chk("file_f2", mem[f2][7:0], v);
    end
    bus_wr(BUS_ACC, ~m_acc[7:0]);
    bus_rd(BUS_ACC, v);
    chk("bus_acc", m_acc[7:0], v);
    bus_rd(BUS_STATUS, v);
    chk("bus_status", m_st[7:0], v);
    bus_rd(8'h90, v);
    chk("bus_unmapped", 8'h00, v);
    @(posedge sys_clk_in);
    second_io_port_in <= 8'h5A;
    repeat (5) @(posedge sys_clk_in);
    #1 chk("flag_set", 8'h01, {7'h00, port_change_flag_out});
    bus_wr(BUS_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk_in);
    #1 chk("flag_held", 8'h01, {7'h00, port_change_flag_out});
    bus_wr({1'b0, PORT2_ADDR}, 8'hA5);
    #1 chk("port_latch", 8'hA5, second_io_port_out);
    exec({OP_CLASS_BYTE, OP_CLR, 1'b1, PORT2_ADDR}, NOP_WORD);
    chk("port_cleared", 8'h00, second_io_port_out);
    bus_wr(BUS_CTRL, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    #1 chk("flag_clear", 8'h00, {7'h00, port_change_flag_out});
    bus_rd(BUS_CTRL, v);
    chk("ctrl_flag", 8'h00, {7'h00, v[CTRL_FLAG]});
    complete_run();
  end
endmodule : tb_top
